/* verilog/gated_16bit_timer.sv */
// Gated 16-bit timer with APB register access and auto-trigger compare
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

module gated_16bit_timer
    import gtimer_pkg::*;
#(
    parameter bit OWNS_SECONDARY_OSC = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic warm_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_clock_pin,
    input wire logic crystal_in_pin,
    input wire logic low_freq_internal_osc,
    input wire logic gate_pin,
    input wire logic comparator_a_output,
    input wire logic comparator_b_output,
    input wire logic timer0_overflow,
    input wire logic ext_trigger,
    output logic auto_trigger,
    output logic overflow_flag,
    output logic gate_event_flag,
    output logic secondary_osc_enable
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    timer_control_t tctl_r;
    gate_control_t gctl_r;
    logic [15:0] count_r;
    logic [15:0] compare_r;
    logic trig_en_r;
    logic ovf_flag_r;
    logic gate_flag_r;
    logic [31:0] prdata_r;
    logic [ASYNC_INPUTS-1:0] pins_sync;
    logic [ASYNC_INPUTS-1:0] pins_prev_r;
    logic [ASYNC_INPUTS-1:0] pins_rise;
    logic [1:0] instr_div_r;
    logic async_tick;
    logic async_tick_r;
    logic src_tick;
    logic [2:0] presc_r;
    logic [2:0] presc_mask;
    logic presc_tick;
    logic gate_src;
    logic gate_pol;
    logic gate_pol_prev_r;
    logic toggle_r;
    logic gate_t;
    logic gate_t_prev_r;
    pulse_state_t pulse_r;
    pulse_state_t pulse_nxt;
    logic gate_val;
    logic gate_val_prev_r;
    logic count_inc;
    logic trig_clear;
    logic trig_r;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic wr_low;
    logic wr_high;
    logic go_done;

    // ------------------------------------------------------------
    // APB slave decode
    // ------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    always_comb
    begin
        unique case (paddr)
            ADDR_TIMER_CONTROL, ADDR_GATE_CONTROL, ADDR_COUNT_LOW, ADDR_COUNT_HIGH,
            ADDR_COMPARE_LOW, ADDR_COMPARE_HIGH, ADDR_EVENT_STATUS, ADDR_TRIGGER_CONTROL:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;
    assign wr_low = wr_en && (paddr == ADDR_COUNT_LOW);
    assign wr_high = wr_en && (paddr == ADDR_COUNT_HIGH);
    assign prdata = prdata_r;

    // Read data captured in setup so it comes out of a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= '0;
        else if (rd_setup)
        begin
            unique case (paddr)
                ADDR_TIMER_CONTROL: prdata_r <= {24'h000000, tctl_r.clock_source, tctl_r.prescale_select,
                    tctl_r.secondary_osc_enable, tctl_r.sync_off, 1'b0, tctl_r.run};
                ADDR_GATE_CONTROL: prdata_r <= {24'h000000, gctl_r[7:3], gate_val,
                    gctl_r.gate_source_select};
                ADDR_COUNT_LOW: prdata_r <= {24'h000000, count_r[7:0]};
                ADDR_COUNT_HIGH: prdata_r <= {24'h000000, count_r[15:8]};
                ADDR_COMPARE_LOW: prdata_r <= {24'h000000, compare_r[7:0]};
                ADDR_COMPARE_HIGH: prdata_r <= {24'h000000, compare_r[15:8]};
                ADDR_EVENT_STATUS: prdata_r <= {30'h00000000, gate_flag_r, ovf_flag_r};
                ADDR_TRIGGER_CONTROL: prdata_r <= {31'h00000000, trig_en_r};
                default: prdata_r <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Only presetn clears these; warm_reset leaves them alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tctl_r <= CONTROL_RESET;
        else if (wr_en && paddr == ADDR_TIMER_CONTROL)
        begin
            tctl_r <= pwdata[7:0];
            tctl_r.unused <= 1'b0;
            // Later instances have no oscillator, bit stays clear
            tctl_r.secondary_osc_enable <= pwdata[3] && OWNS_SECONDARY_OSC;
        end
    end
    assign secondary_osc_enable = tctl_r.secondary_osc_enable;

    // Gate control; the go bit is set by software and cleared by hardware
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gctl_r <= CONTROL_RESET;
        else if (wr_en && paddr == ADDR_GATE_CONTROL)
        begin
            gctl_r <= pwdata[7:0];
            gctl_r.gate_level_status <= 1'b0;
            // Software set beats a hardware clear in the same cycle
            gctl_r.pulse_acquire_go <= pwdata[3] && pwdata[4];
        end
        else if (go_done || !gctl_r.gate_single_pulse_mode)
            gctl_r.pulse_acquire_go <= 1'b0;
    end

    // Compare value and trigger enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_r <= COUNT_MAX;
            trig_en_r <= 1'b0;
        end
        else if (wr_en)
        begin
            if (paddr == ADDR_COMPARE_LOW)
                compare_r[7:0] <= pwdata[7:0];
            if (paddr == ADDR_COMPARE_HIGH)
                compare_r[15:8] <= pwdata[7:0];
            if (paddr == ADDR_TRIGGER_CONTROL)
                trig_en_r <= pwdata[TRIGGER_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    sync_bank #(
        .WIDTH(ASYNC_INPUTS)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({comparator_b_output, comparator_a_output, gate_pin,
            low_freq_internal_osc, crystal_in_pin, external_clock_pin}),
        .sync_out(pins_sync)
    );

    // Edge history, read only after the second flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pins_prev_r <= '0;
        else
            pins_prev_r <= pins_sync;
    end
    assign pins_rise = pins_sync & ~pins_prev_r;

    // ------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------
    // Instruction clock is the system clock divided by four
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            instr_div_r <= '0;
        else
            instr_div_r <= instr_div_r + 2'h1;
    end

    // Rising edges of the slow sources
    always_comb
    begin
        if (tctl_r.clock_source == CLK_LFOSC)
            async_tick = pins_rise[2];
        else if (tctl_r.secondary_osc_enable)
            async_tick = pins_rise[1];
        else
            async_tick = pins_rise[0];
    end

    // Extra resync stage; direct mode trades alignment for a cycle of latency
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            async_tick_r <= 1'b0;
        else
            async_tick_r <= async_tick;
    end

    always_comb
    begin
        unique case (tctl_r.clock_source)
            CLK_SYSTEM: src_tick = 1'b1;
            CLK_INSTR: src_tick = (instr_div_r == INSTR_DIV_LAST);
            default: src_tick = tctl_r.sync_off ? async_tick : async_tick_r;
        endcase
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    assign presc_mask = 3'((4'h1 << tctl_r.prescale_select) - 4'h1);
    assign presc_tick = src_tick && ((presc_r & presc_mask) == presc_mask);

    // A count write restarts the division
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc_r <= '0;
        else if (warm_reset || wr_low || wr_high || !tctl_r.run)
            presc_r <= '0;
        else if (src_tick)
            presc_r <= presc_r + 3'h1;
    end

    // ------------------------------------------------------------
    // Gate conditioning chain
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (gctl_r.gate_source_select)
            GSRC_COMP_B: gate_src = pins_sync[5];
            GSRC_COMP_A: gate_src = pins_sync[4];
            GSRC_TIMER0: gate_src = timer0_overflow;
            default: gate_src = pins_sync[3];
        endcase
    end
    // Active level normalised to high
    assign gate_pol = gctl_r.gate_polarity ? gate_src : !gate_src;

    // Toggle flop on rising active edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gate_pol_prev_r <= 1'b0;
            toggle_r <= 1'b0;
        end
        else
        begin
            gate_pol_prev_r <= gate_pol;
            if (warm_reset || !gctl_r.gate_toggle_mode || !tctl_r.run)
                toggle_r <= 1'b0;
            else if (gate_pol && !gate_pol_prev_r)
                toggle_r <= !toggle_r;
        end
    end
    assign gate_t = gctl_r.gate_toggle_mode ? toggle_r : gate_pol;

    // Single pulse: wait for rising edge, open, close on trailing edge
    always_comb
    begin
        pulse_nxt = pulse_r;
        go_done = 1'b0;
        unique case (pulse_r)
            PULSE_IDLE:
                if (gctl_r.pulse_acquire_go)
                    pulse_nxt = PULSE_ARMED;
            PULSE_ARMED:
                if (!gctl_r.pulse_acquire_go)
                    pulse_nxt = PULSE_IDLE;
                else if (gate_t && !gate_t_prev_r)
                    pulse_nxt = PULSE_OPEN;
            PULSE_OPEN:
                if (!gate_t)
                begin
                    pulse_nxt = PULSE_IDLE;
                    go_done = 1'b1;
                end
            default:
                pulse_nxt = PULSE_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_r <= PULSE_IDLE;
            gate_t_prev_r <= 1'b0;
        end
        else
        begin
            gate_t_prev_r <= gate_t;
            if (warm_reset || !gctl_r.gate_single_pulse_mode)
                pulse_r <= PULSE_IDLE;
            else
                pulse_r <= pulse_nxt;
        end
    end

    // Level seen by the counter, whatever the gate enable says
    assign gate_val = gctl_r.gate_single_pulse_mode ? (gate_t && pulse_r == PULSE_OPEN) : gate_t;

    // ------------------------------------------------------------
    // Count enable and auto trigger
    // ------------------------------------------------------------
    assign count_inc = presc_tick && tctl_r.run && (!gctl_r.gate_enable || gate_val);

    // Match against compare value makes it the period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_r <= 1'b0;
        else
            trig_r <= trig_en_r && count_inc && (count_r == compare_r);
    end
    assign auto_trigger = trig_r;
    assign trig_clear = trig_r || ext_trigger;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Priority: byte write, then trigger clear, then increment
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_r <= COUNT_RESET;
        else if (wr_low || wr_high)
        begin
            if (wr_low)
                count_r[7:0] <= pwdata[7:0];
            if (wr_high)
                count_r[15:8] <= pwdata[7:0];
        end
        else if (trig_clear)
            count_r <= COUNT_RESET;
        else if (count_inc)
            count_r <= count_r + 16'h0001;
    end

    // ------------------------------------------------------------
    // Event flags, write one to clear, set wins
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gate_val_prev_r <= 1'b0;
        else
            gate_val_prev_r <= gate_val;
    end

    // Trigger clears never reach the overflow flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovf_flag_r <= 1'b0;
        else if (count_inc && !trig_clear && !wr_low && !wr_high && count_r == COUNT_MAX)
            ovf_flag_r <= 1'b1;
        else if (wr_en && paddr == ADDR_EVENT_STATUS && pwdata[STATUS_OVERFLOW_BIT])
            ovf_flag_r <= 1'b0;
    end

    // Falling gate level, independent of gate enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gate_flag_r <= 1'b0;
        else if (gate_val_prev_r && !gate_val)
            gate_flag_r <= 1'b1;
        else if (wr_en && paddr == ADDR_EVENT_STATUS && pwdata[STATUS_GATE_EVENT_BIT])
            gate_flag_r <= 1'b0;
    end

    assign overflow_flag = ovf_flag_r;
    assign gate_event_flag = gate_flag_r;

endmodule : gated_16bit_timer

/* verilog/gtimer_pkg.sv */
// Shared constants, field layouts and types for the gated 16-bit timer
package gtimer_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_GATE_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h08;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_COMPARE_LOW = 8'h10;
    localparam logic [7:0] ADDR_COMPARE_HIGH = 8'h14;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h18;
    localparam logic [7:0] ADDR_TRIGGER_CONTROL = 8'h1c;

    // ------------------------------------------------------------
    // Field encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CLK_LFOSC = 2'h3;
    localparam logic [1:0] CLK_PIN_OR_XTAL = 2'h2;
    localparam logic [1:0] CLK_SYSTEM = 2'h1;
    localparam logic [1:0] CLK_INSTR = 2'h0;
    localparam logic [1:0] GSRC_COMP_B = 2'h3;
    localparam logic [1:0] GSRC_COMP_A = 2'h2;
    localparam logic [1:0] GSRC_TIMER0 = 2'h1;
    localparam logic [1:0] GSRC_PIN = 2'h0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam int STATUS_OVERFLOW_BIT = 0;
    localparam int STATUS_GATE_EVENT_BIT = 1;
    localparam int TRIGGER_ENABLE_BIT = 0;
    localparam int SYNC_STAGES = 2;
    localparam int ASYNC_INPUTS = 6;

    // ------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] clock_source;
        logic [1:0] prescale_select;
        logic secondary_osc_enable;
        logic sync_off;
        logic unused;
        logic run;
    } timer_control_t;

    typedef struct packed {
        logic gate_enable;
        logic gate_polarity;
        logic gate_toggle_mode;
        logic gate_single_pulse_mode;
        logic pulse_acquire_go;
        logic gate_level_status;
        logic [1:0] gate_source_select;
    } gate_control_t;

    // Single-pulse acquisition states
    typedef enum logic [2:0] {
        PULSE_IDLE = 3'b001,
        PULSE_ARMED = 3'b010,
        PULSE_OPEN = 3'b100
    } pulse_state_t;

endpackage : gtimer_pkg

/* verilog/sync_bank.sv */
// Bank of two-flop synchronisers for asynchronous inputs
`timescale 1ns/100ps

module sync_bank
    import gtimer_pkg::*;
#(
    parameter int WIDTH = ASYNC_INPUTS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // One pair of flops per input
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_sync
            logic [SYNC_STAGES-1:0] stage_r;
            // First stage feeds only the second
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    stage_r <= '0;
                else
                    stage_r <= {stage_r[SYNC_STAGES-2:0], async_in[i]};
            end
            assign sync_out[i] = stage_r[SYNC_STAGES-1];
        end
    endgenerate

endmodule : sync_bank

/* tb/gtimer_assertions.sv */
// Port checker for the gated 16-bit timer
`timescale 1ns/100ps
module gtimer_assertions
    import gtimer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic auto_trigger,
    input wire logic overflow_flag,
    input wire logic gate_event_flag,
    input wire logic secondary_osc_enable
);
    // ------------------------------------------------------------
    // Bus qualifiers and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Access phase decodes
    wire logic acc = psel && penable;
    wire logic ctl_wr = acc && pwrite && paddr == ADDR_TIMER_CONTROL;
    wire logic st_wr = acc && pwrite && paddr == ADDR_EVENT_STATUS;
    sequence s_trig_pulse;
        auto_trigger ##1 !auto_trigger;
    endsequence
    a_bit1_zero: assert property (
        acc && !pwrite && paddr == ADDR_TIMER_CONTROL |-> prdata[31:8] == 24'h0 && !prdata[1])
        else $error("control read shows a set bit 1 or upper bit");
    a_osc_load: assert property (ctl_wr && pwdata[3] |=> secondary_osc_enable)
        else $error("oscillator enable did not follow the write");
    a_osc_hold: assert property (!ctl_wr |=> $stable(secondary_osc_enable))
        else $error("oscillator enable changed without a write");
    a_mapped_ok: assert property (
        acc && paddr <= ADDR_TRIGGER_CONTROL && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error response on a mapped register");
    a_trig_single: assert property (auto_trigger |-> s_trig_pulse)
        else $error("trigger pulse longer than one cycle");
    a_trig_no_ovf: assert property (auto_trigger && !overflow_flag |=> !overflow_flag)
        else $error("trigger clear raised the overflow flag");
    a_ovf_sticky: assert property (overflow_flag && !st_wr |=> overflow_flag)
        else $error("overflow flag dropped without a clear");
    a_gate_sticky: assert property (gate_event_flag && !st_wr |=> gate_event_flag)
        else $error("gate event flag dropped without a clear");
endmodule : gtimer_assertions

bind gated_16bit_timer gtimer_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pslverr, .auto_trigger, .overflow_flag, .gate_event_flag, .secondary_osc_enable);

/* tb/gtimer_partner.sv */
// Oscillators and gate sources facing the timer
`timescale 1ns/100ps
module gtimer_partner
(
    input wire logic pclk,
    input wire logic lvl,
    input wire logic [1:0] gsel,
    output logic ext_clk,
    output logic xtal,
    output logic lfosc,
    output logic gate,
    output logic cmp_a,
    output logic cmp_b
);
    logic [3:0] ph_r = 4'h0;
    // Free-running oscillators, periods 4, 8 and 16 cycles
    always_ff @(posedge pclk)
    begin
        ph_r <= ph_r + 4'h1;
    end
    assign ext_clk = ph_r[1];
    assign lfosc = ph_r[2];
    assign xtal = ph_r[3];
    localparam logic [1:0] GSRC_SEL0 = 2'h0;
    // Unselected sources show the inverse, so a wrong select is seen
    assign gate = (gsel == GSRC_SEL0) ? lvl : !lvl;
    assign cmp_a = (gsel == 2'h2) ? lvl : !lvl;
    assign cmp_b = (gsel == 2'h3) ? lvl : !lvl;
endmodule : gtimer_partner

/* tb/tb_gated_16bit_timer.sv */
// Self-checking bench for the gated 16-bit timer
`timescale 1ns/100ps
module tb_gated_16bit_timer
    import gtimer_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, warm_reset = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, r;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ext_clk, xtal, lfosc, gate, cmp_a, cmp_b, t0, lvl = 1'b0, ext_trigger = 1'b0;
    logic auto_trigger, overflow_flag, gate_event_flag, osc_en, last_err;
    logic [1:0] gsel = 2'h0;
    int failures = 0, n_compared = 0, n;
    // Clock/gate setting per case: ctl, gate ctl, level, cycles to overflow (0 = hold)
    logic [31:0] tbl [19] = '{32'h41000010, 32'h51000020, 32'h61000040, 32'h71000080, 32'h01000040,
        32'h81000040, 32'h85000040, 32'h89000100, 32'hc1000080, 32'h40000000, 32'h41c00000, 32'h41c08010,
        32'h41808000, 32'h41800010, 32'h41400010, 32'h41c18010, 32'h41c28010, 32'h41c38010, 32'h41e08000};
    assign t0 = (gsel == GSRC_TIMER0) ? lvl : !lvl;
    initial
    begin
        forever #10 pclk = !pclk;
    end
    gated_16bit_timer i_dut (.pclk, .presetn, .warm_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_clock_pin(ext_clk), .crystal_in_pin(xtal), .low_freq_internal_osc(lfosc),
        .gate_pin(gate), .comparator_a_output(cmp_a), .comparator_b_output(cmp_b), .timer0_overflow(t0),
        .ext_trigger, .auto_trigger, .overflow_flag, .gate_event_flag, .secondary_osc_enable(osc_en));
    gtimer_partner i_partner (.pclk, .lvl, .gsel, .ext_clk, .xtal, .lfosc, .gate, .cmp_a, .cmp_b);
    // ------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int k = 0; k == 0 || pready !== 1'b1; k++)
        begin
            if (k == 50)
                chk("bus wait", 8'h0, 8'h1);
            if (k == 50)
                finish_test();
            @(posedge pclk);
        end
        r = prdata[7:0];
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic wait_hi(ref logic s, input int lim);
        for (n = 0; s !== 1'b1 && n < lim; n++)
            @(posedge pclk);
    endtask : wait_hi
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, ADDR_TIMER_CONTROL, 8'h00);
        chk("control reset", 8'h00, r);
        apb(1'b0, ADDR_GATE_CONTROL, 8'h00);
        chk("gate reset", 8'h00, r & 8'hfb);
        apb(1'b0, ADDR_COUNT_LOW, 8'h00);
        chk("count reset", 8'h00, r);
        wr(ADDR_TIMER_CONTROL, 8'hff);
        chk("osc enable", 8'h01, 8'(osc_en));
        apb(1'b0, ADDR_TIMER_CONTROL, 8'h00);
        chk("control readback", 8'hfd, r);
        apb(1'b0, 8'h20, 8'h00);
        chk("unmapped error", 8'h01, 8'(last_err));
    endtask : t_reset
    // Load fff0 and time the rollover from the run write
    task automatic run_case(input logic [31:0] e);
        int x;
        x = int'(e[14:0]);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        lvl <= e[15];
        gsel <= e[17:16];
        wr(ADDR_EVENT_STATUS, 8'h03);
        wr(ADDR_GATE_CONTROL, e[23:16]);
        wr(ADDR_COUNT_LOW, 8'hf0);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_TIMER_CONTROL, e[31:24]);
        wait_hi(overflow_flag, 400);
        chk("rollover time", 8'h1, 8'(x > 0 ? n >= x - x / 8 && n <= x + x / 8 + 6 : n == 400));
        apb(1'b0, ADDR_GATE_CONTROL, 8'h00);
        if (e[21:20] == 2'h0)
            chk("gate level", 8'(e[15] == e[22]), 8'(r[2]));
    endtask : run_case
    task automatic t_trigger();
        lvl <= 1'b1;
        wr(ADDR_EVENT_STATUS, 8'h03);
        wr(ADDR_GATE_CONTROL, 8'h40);
        wr(ADDR_EVENT_STATUS, 8'h03);
        lvl <= 1'b0;
        wait_hi(gate_event_flag, 20);
        chk("gate event", 8'h1, 8'(n < 20));
        wr(ADDR_TIMER_CONTROL, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_COMPARE_LOW, 8'h08);
        wr(ADDR_COMPARE_HIGH, 8'h00);
        wr(ADDR_TRIGGER_CONTROL, 8'h01);
        // Synchronised instruction clock; period is nine ticks of four cycles
        wr(ADDR_TIMER_CONTROL, 8'h01);
        wait_hi(auto_trigger, 100);
        chk("first trigger", 8'h1, 8'(n >= 28 && n <= 40));
        @(posedge pclk);
        wait_hi(auto_trigger, 100);
        chk("trigger period", 8'h1, 8'(n >= 34 && n <= 36));
        chk("no overflow", 8'h0, 8'(overflow_flag));
        wr(ADDR_TRIGGER_CONTROL, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        // Clear pulse lands on the access edge of the byte write
        fork
            wr(ADDR_COUNT_LOW, 8'h55);
            begin
                @(posedge pclk);
                ext_trigger <= 1'b1;
                @(posedge pclk);
                ext_trigger <= 1'b0;
            end
        join
        apb(1'b0, ADDR_COUNT_LOW, 8'h00);
        chk("write beats clear", 8'h55, r);
        ext_trigger <= 1'b1;
        @(posedge pclk);
        ext_trigger <= 1'b0;
        apb(1'b0, ADDR_COUNT_LOW, 8'h00);
        chk("outside clear", 8'h00, r);
    endtask : t_trigger
    task automatic t_pulse();
        wr(ADDR_TIMER_CONTROL, 8'h41);
        wr(ADDR_GATE_CONTROL, 8'h08);
        apb(1'b0, ADDR_GATE_CONTROL, 8'h00);
        chk("go refused", 8'h0, 8'(r[3]));
        wr(ADDR_GATE_CONTROL, 8'hd8);
        apb(1'b0, ADDR_GATE_CONTROL, 8'h00);
        chk("go armed", 8'h1, 8'(r[3]));
        lvl <= 1'b1;
        repeat (8) @(posedge pclk);
        lvl <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, ADDR_GATE_CONTROL, 8'h00);
        chk("go done", 8'h0, 8'(r[3]));
        // A second pulse without rearming must not count
        wr(ADDR_COUNT_LOW, 8'h00);
        lvl <= 1'b1;
        repeat (8) @(posedge pclk);
        lvl <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, ADDR_COUNT_LOW, 8'h00);
        chk("no second pulse", 8'h00, r);
        wr(ADDR_TIMER_CONTROL, 8'h30);
        warm_reset <= 1'b1;
        @(posedge pclk);
        warm_reset <= 1'b0;
        apb(1'b0, ADDR_TIMER_CONTROL, 8'h00);
        chk("warm keeps", 8'h30, r);
    endtask : t_pulse
    // Main sequence after 16 cycles of reset
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        foreach (tbl[i])
            run_case(tbl[i]);
        t_trigger();
        t_pulse();
        finish_test();
    end
endmodule : tb_gated_16bit_timer
